/* File: src/rtc_top.v */
// Serial-bus clock and calendar core: bus slave, control, oscillator watch.
// Behaviour
// - Master reads and writes all seven time counters.
// - Year divisible by four gives 29-day February.
// - Rate bits pick 1Hz, 4.096k, 8.192k, 32.768k.
// - Wave disabled: pin holds the OUT bit level.
// - Wave enable routes divided crystal to pin.
// - Counters advance on falling edge of 1Hz.
// - Oscillator halt sets the stop flag.
// - Stop flag sticks; only a zero write clears.
// - Seconds bit 7 disables the oscillator.
// - Stop flag rises 100 ms after halt.
// - Power return blocks bus 2 ms if running.
// - Packed BCD counters, unused bits read zero.
// - Hours bit 6 selects 12/24-hour, bit5 PM.
// - Below power-fail threshold, bus ignored, time runs.
// - Date wraps by month length, leap February.
`timescale 1ns/100ps
`include "rtc_consts.vh"
module rtc_top #(
  parameter [23:0] OSF_CYC = `RTC_OSF_CYC,
  parameter [23:0] REC_CYC = `RTC_REC_CYC
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_scl,
  input  wire i_sda,
  output reg  o_sda,
  output reg  o_sda_oe_n,
  input  wire i_osc,
  input  wire i_below_power_fail_threshold,
  output reg  o_wave_or_level_pin,
  output wire o_wave_or_level_pin_oe_n
);
  // ****************************************************************
  // Bus engine states
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX   = 5'b00010;
  localparam [4:0] ST_ACK  = 5'b00100;
  localparam [4:0] ST_TX   = 5'b01000;
  localparam [4:0] ST_MACK = 5'b10000;
  localparam [1:0] PH_ADDR = 2'd0;
  localparam [1:0] PH_PTR  = 2'd1;
  localparam [1:0] PH_DATA = 2'd2;
  localparam [7:0] CTRL_RST = `RTC_CTRL_RST;

  reg  [4:0]  state_reg;
  reg  [3:0]  cnt_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  tx_reg;
  reg  [2:0]  ptr_reg;
  reg  [1:0]  phase_reg;
  reg         rw_reg;
  reg         mack_reg;
  reg         scl_q;
  reg         sda_q;
  reg         wr_reg;
  reg  [2:0]  wr_addr_reg;
  reg  [7:0]  wr_data_reg;

  // Control register fields.
  reg         out_reg;
  reg         osf_reg;
  reg         square_wave_enable_reg;
  reg  [1:0]  rate_reg;

  // Oscillator watch and power recovery.
  reg         osc_q;
  reg         run_reg;
  reg         osf_set_reg;
  reg  [23:0] idle_reg;
  reg         vlow_q;
  reg  [23:0] rec_reg;

  wire [7:0]  sec;
  wire [7:0]  min;
  wire [7:0]  hour;
  wire [7:0]  wday;
  wire [7:0]  date;
  wire [7:0]  mon;
  wire [7:0]  year;
  wire        sec_tick;
  reg  [7:0]  rd_byte;

  // ****************************************************************
  // Oscillator gating and watch
  // ****************************************************************
  wire osc_dis  = sec[`RTC_B_OSCDIS];  // Writing 1 stops the crystal.
  wire osc_rise = i_osc & ~osc_q & ~osc_dis;
  wire osc_lvl  = osc_q & ~osc_dis;

  // A crystal that shows no rising edge for the stop delay is declared
  // halted; disabling it lands here too, so both paths set the flag the
  // same way. The counter saturates so a long halt fires only once.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_q       <= 1'b0;
      idle_reg    <= 24'h000000;
      run_reg     <= 1'b0;
      osf_set_reg <= 1'b0;
    end else begin
      osc_q       <= i_osc;
      osf_set_reg <= 1'b0;
      if (osc_rise) begin
        idle_reg <= 24'h000000;
        run_reg  <= 1'b1;
      end else if (idle_reg != OSF_CYC - 24'h000001) begin
        idle_reg <= idle_reg + 24'h000001;
      end else if (run_reg) begin
        run_reg     <= 1'b0;
        osf_set_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Power-return recovery window
  // ****************************************************************
  wire power_back = vlow_q & ~i_below_power_fail_threshold;
  wire rec_arm    = power_back & ~osc_dis & run_reg;
  // The arming cycle itself is blocked too, so no start slips in before the wait loads.
  wire bus_ok     = ~i_below_power_fail_threshold & ~rec_arm & (rec_reg == 24'h000000);

  // The wait is taken only with the crystal enabled and running.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vlow_q  <= 1'b0;
      rec_reg <= 24'h000000;
    end else begin
      vlow_q <= i_below_power_fail_threshold;
      if (rec_arm)
        rec_reg <= REC_CYC;
      else if (rec_reg != 24'h000000)
        rec_reg <= rec_reg - 24'h000001;
    end
  end

  // ****************************************************************
  // Control and status register
  // ****************************************************************
  wire ctrl_wr = wr_reg & (wr_addr_reg == `RTC_A_CTRL);

  // A halt reported in the same cycle as a clearing write still sets
  // the flag, so no stop event is ever lost.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_reg  <= CTRL_RST[`RTC_B_OUT];
      osf_reg  <= CTRL_RST[`RTC_B_OSF];
      square_wave_enable_reg <= CTRL_RST[`RTC_B_SQUARE_WAVE_ENABLE];
      rate_reg <= CTRL_RST[`RTC_B_RSHI:`RTC_B_RSLO];
    end else begin
      if (ctrl_wr) begin
        out_reg  <= wr_data_reg[`RTC_B_OUT];
        square_wave_enable_reg <= wr_data_reg[`RTC_B_SQUARE_WAVE_ENABLE];
        rate_reg <= wr_data_reg[`RTC_B_RSHI:`RTC_B_RSLO];
        osf_reg  <= osf_set_reg | (osf_reg & wr_data_reg[`RTC_B_OSF]);
      end else begin
        osf_reg  <= osf_reg | osf_set_reg;
      end
    end
  end

  // ****************************************************************
  // Counters and wave output
  // ****************************************************************
  rtc_cal u_cal (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_tick    (sec_tick),
    .i_wr      (wr_reg),
    .i_wr_addr (wr_addr_reg),
    .i_wr_data (wr_data_reg),
    .o_sec     (sec),
    .o_min     (min),
    .o_hour    (hour),
    .o_wday    (wday),
    .o_date    (date),
    .o_mon     (mon),
    .o_year    (year)
  );

  rtc_wave u_wave (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_osc_rise (osc_rise),
    .i_osc_lvl  (osc_lvl),
    .i_rate     (rate_reg),
    .i_square_wave_enable     (square_wave_enable_reg),
    .i_out_lvl  (out_reg),
    .o_pin_oe_n (o_wave_or_level_pin_oe_n),
    .o_sec_tick (sec_tick)
  );

  // The wave pin only ever pulls low; its enable carries the waveform.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      o_wave_or_level_pin <= 1'b0;
    else
      o_wave_or_level_pin <= 1'b0;
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always @* begin
    case (ptr_reg)
      `RTC_A_SEC:  rd_byte = sec;
      `RTC_A_MIN:  rd_byte = min;
      `RTC_A_HOUR: rd_byte = hour;
      `RTC_A_WDAY: rd_byte = wday;
      `RTC_A_DATE: rd_byte = date;
      `RTC_A_MON:  rd_byte = mon;
      `RTC_A_YEAR: rd_byte = year;
      default:     rd_byte = {out_reg, 1'b0, osf_reg, square_wave_enable_reg, 2'b00, rate_reg};
    endcase
  end

  // ****************************************************************
  // Serial bus slave
  // ****************************************************************
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire start    = scl_q & i_scl & sda_q & ~i_sda;
  wire stop     = scl_q & i_scl & ~sda_q & i_sda;

  // Pins are sampled on the core clock; the master's slow serial clock
  // leaves many core cycles per bit. Start and stop override any state,
  // and a blocked bus is held idle with the data line released.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 3'h0;
      phase_reg   <= PH_ADDR;
      rw_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      wr_reg      <= 1'b0;
      wr_addr_reg <= 3'h0;
      wr_data_reg <= 8'h00;
      o_sda       <= 1'b0;
      o_sda_oe_n  <= 1'b1;
    end else begin
      scl_q  <= i_scl;
      sda_q  <= i_sda;
      wr_reg <= 1'b0;
      o_sda  <= 1'b0;
      if (!bus_ok || stop) begin
        state_reg  <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (start) begin
        state_reg  <= ST_RX;
        phase_reg  <= PH_ADDR;
        cnt_reg    <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], i_sda};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (phase_reg == PH_ADDR) begin
                if (sh_reg[7:1] == `RTC_DEV_ADDR) begin
                  rw_reg     <= sh_reg[0];
                  state_reg  <= ST_ACK;
                  o_sda_oe_n <= 1'b0;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (phase_reg == PH_PTR) begin
                ptr_reg    <= sh_reg[2:0];
                state_reg  <= ST_ACK;
                o_sda_oe_n <= 1'b0;
              end else begin
                wr_reg      <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= sh_reg;
                ptr_reg     <= ptr_reg + 3'h1;
                state_reg   <= ST_ACK;
                o_sda_oe_n  <= 1'b0;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (phase_reg == PH_ADDR && rw_reg) begin
                tx_reg     <= {rd_byte[6:0], 1'b0};
                ptr_reg    <= ptr_reg + 3'h1;
                o_sda_oe_n <= rd_byte[7];
                state_reg  <= ST_TX;
              end else begin
                phase_reg  <= (phase_reg == PH_ADDR) ? PH_PTR : PH_DATA;
                o_sda_oe_n <= 1'b1;
                state_reg  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == 4'h7) begin
                o_sda_oe_n <= 1'b1;
                mack_reg   <= 1'b0;
                state_reg  <= ST_MACK;
              end else begin
                o_sda_oe_n <= tx_reg[7];
                tx_reg     <= {tx_reg[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_reg <= ~i_sda;
            end else if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (mack_reg) begin
                tx_reg     <= {rd_byte[6:0], 1'b0};
                ptr_reg    <= ptr_reg + 3'h1;
                o_sda_oe_n <= rd_byte[7];
                state_reg  <= ST_TX;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            o_sda_oe_n <= 1'b1;
          end
          default: begin
            state_reg  <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // rtc_top

/* File: src/rtc_consts.vh */
// Register map, field positions, reset values and timing counts of the clock core.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define RTC_A_SEC    3'h0
`define RTC_A_MIN    3'h1
`define RTC_A_HOUR   3'h2
`define RTC_A_WDAY   3'h3
`define RTC_A_DATE   3'h4
`define RTC_A_MON    3'h5
`define RTC_A_YEAR   3'h6
`define RTC_A_CTRL   3'h7
// ****************************************************************
// Field positions and masks
// ****************************************************************
`define RTC_B_OSCDIS 7
`define RTC_B_HR12   6
`define RTC_B_PM     5
`define RTC_B_OUT    7
`define RTC_B_OSF    5
`define RTC_B_SQUARE_WAVE_ENABLE   4
`define RTC_B_RSHI   1
`define RTC_B_RSLO   0
`define RTC_M_MIN    8'h7F
`define RTC_M_HOUR   8'h7F
`define RTC_M_WDAY   8'h07
`define RTC_M_DATE   8'h3F
`define RTC_M_MON    8'h1F
// ****************************************************************
// Reset values and bus address
// ****************************************************************
`define RTC_CTRL_RST 8'hB3
`define RTC_SEC_RST  8'h00
`define RTC_ONE_RST  8'h01
`define RTC_DEV_ADDR 7'h52
// ****************************************************************
// Timing
// ****************************************************************
`define RTC_CLK_KHZ  24'd125000
`define RTC_OSF_MS   24'd100
`define RTC_REC_MS   24'd2
`define RTC_OSF_CYC  (`RTC_OSF_MS * `RTC_CLK_KHZ)
`define RTC_REC_CYC  (`RTC_REC_MS * `RTC_CLK_KHZ)
`endif

/* File: src/rtc_wave.v */
// Crystal divider, square-wave or level pin driver and one-second tick.
`timescale 1ns/100ps
`include "rtc_consts.vh"
module rtc_wave (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_osc_rise,
  input  wire       i_osc_lvl,
  input  wire [1:0] i_rate,
  input  wire       i_square_wave_enable,
  input  wire       i_out_lvl,
  output reg        o_pin_oe_n,
  output reg        o_sec_tick
);
  reg [14:0] div_reg;
  reg        wave;

  // Pick the divided crystal phase that matches the rate select.
  always @* begin
    case (i_rate)
      2'b00:   wave = div_reg[14];  // 1 Hz.
      2'b01:   wave = div_reg[2];   // 4.096 kHz.
      2'b10:   wave = div_reg[1];   // 8.192 kHz.
      default: wave = i_osc_lvl;    // 32.768 kHz.
    endcase
  end

  // The pin is open drain, so a high level is a released pin.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg    <= 15'h0000;
      o_pin_oe_n <= 1'b1;
      o_sec_tick <= 1'b0;
    end else begin
      if (i_osc_rise)
        div_reg <= div_reg + 15'h0001;
      // The 1 Hz phase falls exactly when the divider wraps.
      o_sec_tick <= i_osc_rise & (div_reg == 15'h7FFF);
      o_pin_oe_n <= i_square_wave_enable ? wave : i_out_lvl;
    end
  end
endmodule // rtc_wave

/* File: src/rtc_cal.v */
// BCD time and calendar counters with a byte write port.
`timescale 1ns/100ps
`include "rtc_consts.vh"
module rtc_cal (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_tick,
  input  wire       i_wr,
  input  wire [2:0] i_wr_addr,
  input  wire [7:0] i_wr_data,
  output reg  [7:0] o_sec,
  output reg  [7:0] o_min,
  output reg  [7:0] o_hour,
  output reg  [7:0] o_wday,
  output reg  [7:0] o_date,
  output reg  [7:0] o_mon,
  output reg  [7:0] o_year
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    end
  endfunction

  // Year mod 4 from BCD digits: tens times ten adds twice the tens.
  function is_leap;
    input [7:0] y;
    begin
      is_leap = (({y[4], 1'b0} + y[1:0]) == 2'b00);
    end
  endfunction

  function [7:0] last_day;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02:   last_day = is_leap(y) ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
        default: last_day = 8'h31;
      endcase
    end
  endfunction

  // ****************************************************************
  // Carry chain
  // ****************************************************************
  wire       h12   = o_hour[`RTC_B_HR12];
  wire [4:0] hr12  = o_hour[4:0];
  wire       c_sec = i_tick & (o_sec[6:0] == 7'h59);
  wire       c_min = c_sec & (o_min == 8'h59);
  wire       c_hr  = c_min & (h12 ? (o_hour[5:0] == 6'h31) : (o_hour[5:0] == 6'h23));
  wire       c_dt  = c_hr & (o_date == last_day(o_mon, o_year));
  wire       c_mo  = c_dt & (o_mon == 8'h12);
  wire [7:0] sec_i = bcd_inc({1'b0, o_sec[6:0]});

  function wr_hit;
    input [2:0] a;
    begin
      wr_hit = i_wr & (i_wr_addr == a);
    end
  endfunction

  // A write wins over a carry into the same register; unused bits stay zero.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sec  <= `RTC_SEC_RST;
      o_min  <= `RTC_SEC_RST;
      o_hour <= `RTC_SEC_RST;
      o_wday <= `RTC_ONE_RST;
      o_date <= `RTC_ONE_RST;
      o_mon  <= `RTC_ONE_RST;
      o_year <= `RTC_SEC_RST;
    end else begin
      if (wr_hit(`RTC_A_SEC))
        o_sec <= i_wr_data;
      else if (i_tick)
        o_sec <= {o_sec[`RTC_B_OSCDIS], c_sec ? 7'h00 : sec_i[6:0]};
      if (wr_hit(`RTC_A_MIN))
        o_min <= i_wr_data & `RTC_M_MIN;
      else if (c_sec)
        o_min <= c_min ? 8'h00 : bcd_inc(o_min);
      if (wr_hit(`RTC_A_HOUR))
        o_hour <= i_wr_data & `RTC_M_HOUR;
      else if (c_min) begin
        if (!h12)
          o_hour <= c_hr ? 8'h00 : bcd_inc(o_hour);
        else if (hr12 == 5'h12)
          o_hour <= {2'b01, o_hour[`RTC_B_PM], 5'h01};
        else if (hr12 == 5'h11)
          o_hour <= {2'b01, ~o_hour[`RTC_B_PM], 5'h12};
        else
          o_hour <= {2'b01, o_hour[`RTC_B_PM], 5'h00} | bcd_inc({3'b000, hr12});
      end
      if (wr_hit(`RTC_A_WDAY))
        o_wday <= i_wr_data & `RTC_M_WDAY;
      else if (c_hr)
        o_wday <= (o_wday == 8'h07) ? 8'h01 : o_wday + 8'h01;
      if (wr_hit(`RTC_A_DATE))
        o_date <= i_wr_data & `RTC_M_DATE;
      else if (c_hr)
        o_date <= c_dt ? 8'h01 : bcd_inc(o_date);
      if (wr_hit(`RTC_A_MON))
        o_mon <= i_wr_data & `RTC_M_MON;
      else if (c_dt)
        o_mon <= c_mo ? 8'h01 : bcd_inc(o_mon);
      if (wr_hit(`RTC_A_YEAR))
        o_year <= i_wr_data;
      else if (c_mo)
        o_year <= (o_year == 8'h99) ? 8'h00 : bcd_inc(o_year);
    end
  end
endmodule // rtc_cal

/* File: verification/rtc_checker.sv */
// Port-level assertions for the serial clock and calendar core.
`timescale 1ns/100ps
module rtc_checker #(
  parameter [23:0] OSF_CYC = 24'd200,
  parameter [23:0] REC_CYC = 24'd50
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda,
  input wire o_sda_oe_n,
  input wire i_osc,
  input wire i_below_power_fail_threshold,
  input wire o_wave_or_level_pin,
  input wire o_wave_or_level_pin_oe_n
);
  // ****************************************************************
  // Pin checks
  // ****************************************************************
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Both pins are open drain, so only their enables may ever move.
  property p_sda_value;
    o_sda == 1'b0;
  endproperty
  a_sda_value: assert property (p_sda_value) else $error("Data pin value not low");
  property p_pin_value;
    o_wave_or_level_pin == 1'b0;
  endproperty
  a_pin_value: assert property (p_pin_value) else $error("Wave pin value not low");
  // The data enable moves one or two clocks after a serial clock fall.
  property p_ack_edge;
    $changed(o_sda_oe_n) |-> !$past(i_scl) && ($past(i_scl, 2) || $past(i_scl, 3));
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("Data enable moved off a clock fall");
  // Moving data while the serial clock is high would read as a start or stop.
  property p_scl_high_hold;
    i_scl && $past(i_scl) |-> $stable(o_sda_oe_n);
  endproperty
  a_scl_high_hold: assert property (p_scl_high_hold) else $error("Data moved in clock high");
  property p_quiet_below;
    i_below_power_fail_threshold [*3] |-> o_sda_oe_n;
  endproperty
  a_quiet_below: assert property (p_quiet_below) else $error("Bus driven below threshold");
  property p_below_release;
    $rose(i_below_power_fail_threshold) |-> ##[0:3] o_sda_oe_n;
  endproperty
  a_below_release: assert property (p_below_release) else $error("Bus not released");
  property p_reset_quiet;
    $fell(i_rst) |-> o_sda_oe_n [*2];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("Bus driven after reset");
  // Without crystal edges or a control write the wave pin cannot move.
  property p_wave_static;
    ($stable(i_osc) && i_scl) [*3] |-> $stable(o_wave_or_level_pin_oe_n);
  endproperty
  a_wave_static: assert property (p_wave_static) else $error("Wave pin moved idle");
endmodule // rtc_checker

/* File: verification/rtc_host.sv */
// Two-wire bus master model that drives the serial clock and releases data.
`timescale 1ns/100ps
module rtc_host #(
  parameter integer HALF = 157
) (
  input  wire i_clk,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda
);
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // A half period of 157 clocks keeps the serial clock under 400 kHz.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task hold;
    begin
      repeat (HALF) @(posedge i_clk);
      #1;
    end
  endtask
  task start_cond;
    begin
      o_sda = 1'b1;
      hold;
      o_scl = 1'b1;
      hold;
      o_sda = 1'b0;
      hold;
      o_scl = 1'b0;
    end
  endtask
  task stop_cond;
    begin
      o_sda = 1'b0;
      hold;
      o_scl = 1'b1;
      hold;
      o_sda = 1'b1;
      hold;
    end
  endtask
  // Data changes only while the clock is low; the line is read late in high.
  task one_bit(input b, output r);
    begin
      o_sda = b;
      hold;
      o_scl = 1'b1;
      hold;
      r = i_sda;
      o_scl = 1'b0;
    end
  endtask
  task put_byte(input [7:0] d, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        one_bit(d[i], r);
      end
      one_bit(1'b1, r);
      ack = ~r;
    end
  endtask
  task get_byte(input last, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        one_bit(1'b1, d[i]);
      end
      one_bit(last, r);
    end
  endtask
endmodule // rtc_host

/* File: verification/i2c_bcd_calendar_clock_test.sv */
// Self-checking bench for the serial clock and calendar core.
`timescale 1ns/100ps
`include "rtc_consts.vh"
module i2c_bcd_calendar_clock_test;
  reg        i_clk;
  reg        i_rst;
  reg        i_osc;
  reg        i_below_power_fail_threshold;
  reg        osc_run;
  reg        a;
  wire       scl;
  wire       host_sda;
  wire       sda_line;
  wire       dut_sda;
  wire       dut_sda_oe_n;
  wire       pin_val;
  wire       pin_oe_n;
  wire       pin_lvl;
  integer    n_fail;
  integer    tests_run;
  integer    seed;
  integer    yr;
  integer    i;
  reg  [7:0] wbuf [0:7];
  reg  [7:0] rbuf [0:7];
  reg  [7:0] expv [0:7];
  // Both lines have pull-ups, so a released enable reads as high.
  assign sda_line = host_sda & (dut_sda_oe_n | dut_sda);
  assign pin_lvl  = pin_oe_n | pin_val;
  rtc_top #(.OSF_CYC(24'd200), .REC_CYC(24'd50)) u_rtc_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line), .o_sda(dut_sda),
    .o_sda_oe_n(dut_sda_oe_n), .i_osc(i_osc),
    .i_below_power_fail_threshold(i_below_power_fail_threshold),
    .o_wave_or_level_pin(pin_val), .o_wave_or_level_pin_oe_n(pin_oe_n));
  rtc_host u_rtc_host (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));
  // ****************************************************************
  // Clocks and helpers
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // The crystal toggles every clock, the fastest rate the core can sample.
  always @(posedge i_clk) begin
    #1;
    if (osc_run) i_osc = ~i_osc;
  end
  function [7:0] bcd(input integer v);
    bcd = 8'((v / 10) * 16 + (v % 10));
  endfunction
  // Month and date that follow the 28th of February in a given year.
  function [15:0] after_feb28(input integer v);
    after_feb28 = (v % 4 == 0) ? 16'h0229 : 16'h0301;
  endfunction
  task complete_run;
    begin
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (e !== g) begin
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task wr(input [2:0] ptr, input integer n);
    integer k;
    begin
      u_rtc_host.start_cond;
      u_rtc_host.put_byte({`RTC_DEV_ADDR, 1'b0}, a);
      chk("addr ack", 8'h01, {7'h00, a});
      u_rtc_host.put_byte({5'h00, ptr}, a);
      for (k = 0; k < n; k = k + 1) begin
        u_rtc_host.put_byte(wbuf[k], a);
        chk("data ack", 8'h01, {7'h00, a});
      end
      u_rtc_host.stop_cond;
    end
  endtask
  task rd(input [2:0] ptr, input integer n);
    integer k;
    begin
      u_rtc_host.start_cond;
      u_rtc_host.put_byte({`RTC_DEV_ADDR, 1'b0}, a);
      chk("addr ack", 8'h01, {7'h00, a});
      u_rtc_host.put_byte({5'h00, ptr}, a);
      u_rtc_host.start_cond;
      u_rtc_host.put_byte({`RTC_DEV_ADDR, 1'b1}, a);
      for (k = 0; k < n; k = k + 1) begin
        u_rtc_host.get_byte(k == n - 1, rbuf[k]);
      end
      u_rtc_host.stop_cond;
    end
  endtask
  // Counts falls of the pin over 256 clocks; one edge of phase slack.
  task meas(input integer e);
    integer k;
    integer c;
    reg     p;
    begin
      c = 0;
      p = pin_lvl;
      for (k = 0; k < 256; k = k + 1) begin
        @(posedge i_clk);
        #1;
        if (p && !pin_lvl) c = c + 1;
        p = pin_lvl;
      end
      if (c == e + 1 || c == e - 1) c = e;
      chk("rate falls", 8'(e), 8'(c));
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin : main
    integer k;
    reg     p;
    i_rst = 1'b1;
    i_osc = 1'b0;
    i_below_power_fail_threshold = 1'b0;
    osc_run = 1'b1;
    n_fail = 0;
    tests_run = 0;
    seed = 32'h1abe;
    a = 1'b0;
    repeat (4) @(posedge i_clk);
    #1 i_rst = 1'b0;
    meas(128);
    rd(3'h7, 1);
    chk("ctrl reset", `RTC_CTRL_RST, rbuf[0]);
    yr = $unsigned($random(seed)) % 100;
    // An odd year also runs the hour in 12-hour form, 11 PM into 12 AM.
    wbuf[0] = 8'h59; wbuf[1] = 8'h59; wbuf[2] = yr[0] ? 8'h71 : 8'h23; wbuf[3] = 8'h07;
    wbuf[4] = 8'h28; wbuf[5] = 8'h02; wbuf[6] = bcd(yr); wbuf[7] = 8'h11;
    wr(3'h0, 8);
    meas(16);
    wbuf[0] = 8'h32;
    wr(3'h7, 1);
    meas(32);
    wbuf[0] = 8'h30;
    wr(3'h7, 1);
    // The seconds step lands on the falling edge of the 1 Hz wave.
    k = 0;
    p = pin_lvl;
    while (!(p && !pin_lvl) && k < 40000) begin
      p = pin_lvl;
      @(posedge i_clk);
      #1;
      k = k + 1;
    end
    if (k == 40000) begin
      chk("1 Hz fall", 8'h01, 8'h00);
      complete_run;
    end
    rd(3'h0, 8);
    expv[0] = 8'h00; expv[1] = 8'h00; expv[2] = yr[0] ? 8'h52 : 8'h00; expv[3] = 8'h01;
    {expv[5], expv[4]} = after_feb28(yr);
    expv[6] = bcd(yr);
    expv[7] = 8'h10;
    for (i = 0; i < 8; i = i + 1) begin
      chk($sformatf("reg%0d", i), expv[i], rbuf[i]);
    end
    wbuf[0] = 8'h01;
    wbuf[1] = 8'h80;
    wr(3'h7, 2);
    chk("pin low", 8'h00, {7'h00, pin_lvl});
    osc_run = 1'b0;
    i_below_power_fail_threshold = 1'b1;
    u_rtc_host.start_cond;
    u_rtc_host.put_byte({`RTC_DEV_ADDR, 1'b0}, a);
    chk("blocked ack", 8'h00, {7'h00, a});
    u_rtc_host.stop_cond;
    i_below_power_fail_threshold = 1'b0;
    rd(3'h7, 1);
    chk("ctrl stop flag", 8'h21, rbuf[0]);
    wbuf[0] = 8'h80;
    wr(3'h7, 1);
    chk("pin high", 8'h01, {7'h00, pin_lvl});
    complete_run;
  end
endmodule // i2c_bcd_calendar_clock_test
bind rtc_top rtc_checker #(.OSF_CYC(OSF_CYC), .REC_CYC(REC_CYC)) u_rtc_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n), .i_osc(i_osc),
  .i_below_power_fail_threshold(i_below_power_fail_threshold),
  .o_wave_or_level_pin(o_wave_or_level_pin),
  .o_wave_or_level_pin_oe_n(o_wave_or_level_pin_oe_n));
